// ### hw/tia_two_wire_control_slave.sv
// two-wire slave with control and channel registers
// Behaviour
// - each start-to-stop frame carries only one register data byte
// - receiver pulls data low through the ninth clock; sender releases
// - unmatched slave address leaves data released during acknowledge
// - once no more bytes are taken, next byte is not acknowledged
// - write: address with direction 0, index byte, data byte, each acked
// - read: index written, repeated start, direction 1, one byte returned
// - register indices zero to nineteen form the control map
// - global control register resets to zero
// - writing one to control bit 7 restores all registers to defaults
// - control bit 6 powers down all four channels
// - control bit 0 mirrors channel register writes to every channel
// - channel-1 amplitude/rate register is read/write, resets to zero
// - its bits 7:4 select bandwidth and drive the analog stage
// - its bits 3:0 select output swing and drive the analog stage
// - only slave address 0001100, sent msb first, is answered
// - registers take effect only while serial control is enabled
// - channel registers sit at indices 1, 7, 13 and 19
`timescale 1ns/100ps
`include "tia_map.svh"
module tia_two_wire_control_slave (
	input  wire logic          ref_clk,               // 50 MHz clock
	input  wire logic          rst_n,                 // async reset
	input  wire logic          scl_clk,               // serial clock pin
	input  wire logic          sda_in,                // serial data pin
	output logic               sda_out,               // data drive level
	output logic               sda_oe,                // data pulled low
	input  wire logic          serial_control_enable, // interface enable
	output logic               power_down_all,        // all channels off
	output tia_pkg::tia_quad_t bandwidth_select,      // 4 bits per chan
	output tia_pkg::tia_quad_t swing_select           // 4 bits per chan
);
	import tia_pkg::*;

	tia_reg_if rif();

	tia_reg_bank u_bank (
		.clk   (ref_clk),
		.rst_n (rst_n),
		.rif   (rif.bank)
	);

	// ---- reference domain: frame tracking ----

	logic [2:0] pin_s;
	logic       scl_s;
	logic       sda_s;
	logic       en_s;
	logic       scl_p_reg;
	logic       sda_p_reg;
	logic       frame_reg;
	logic       frame_next;
	logic       hold_reg;
	logic       hold_next;
	logic       link_rst_n_reg;
	logic       start_det;
	logic       stop_det;

	tia_sync #(.WIDTH(3)) u_pin_sync (
		.clk   (ref_clk),
		.rst_n (rst_n),
		.d     ({serial_control_enable, sda_in, scl_clk}),
		.q     (pin_s)
	);

	assign scl_s = pin_s[0];
	assign sda_s = pin_s[1];
	assign en_s  = pin_s[2];

	assign start_det  = scl_s && scl_p_reg && sda_p_reg && !sda_s;
	assign stop_det   = scl_s && scl_p_reg && !sda_p_reg && sda_s;
	assign frame_next = start_det || (frame_reg && !stop_det);
	// a start holds the link engine cleared until the clock drops
	assign hold_next  = start_det || (hold_reg && scl_s);

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_p_reg      <= 1'b0;
			sda_p_reg      <= 1'b0;
			frame_reg      <= 1'b0;
			hold_reg       <= 1'b0;
			link_rst_n_reg <= 1'b0;
		end
		else
		begin
			scl_p_reg      <= scl_s;
			sda_p_reg      <= sda_s;
			frame_reg      <= frame_next;
			hold_reg       <= hold_next;
			link_rst_n_reg <= frame_next && !hold_next;
		end
	end

	// ---- reference domain: write event and index crossing ----

	logic      wr_tgl_reg;
	tia_byte_t index_reg;
	tia_byte_t wdata_reg;
	logic      tgl_s;
	tia_byte_t idx_s;
	logic      tgl_p_reg;

	tia_sync #(.WIDTH(9)) u_xing_sync (
		.clk   (ref_clk),
		.rst_n (rst_n),
		.d     ({wr_tgl_reg, index_reg}),
		.q     ({tgl_s, idx_s})
	);

	// data word is stable from the toggle until the next frame
	assign rif.wr_en   = (tgl_s ^ tgl_p_reg) && en_s;
	assign rif.wr_idx  = idx_s;
	assign rif.wr_data = wdata_reg;
	assign rif.rd_idx  = idx_s;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			tgl_p_reg <= 1'b0;
		else
			tgl_p_reg <= tgl_s;
	end

	// ---- reference domain: analog control outputs ----

	tia_quad_t bw_next;
	tia_quad_t swing_next;

	assign bw_next = {rif.amp_rate[3][7:4], rif.amp_rate[2][7:4],
		rif.amp_rate[1][7:4], rif.amp_rate[0][7:4]};
	assign swing_next = {rif.amp_rate[3][3:0], rif.amp_rate[2][3:0],
		rif.amp_rate[1][3:0], rif.amp_rate[0][3:0]};

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			power_down_all   <= 1'b0;
			bandwidth_select <= '0;
			swing_select     <= '0;
		end
		else
		begin
			power_down_all   <= en_s && rif.pd;
			bandwidth_select <= en_s ? bw_next : '0;
			swing_select     <= en_s ? swing_next : '0;
		end
	end

	// ---- link domain: byte engine on the serial clock ----

	tia_link_st_e state_reg;
	tia_link_st_e state_next;
	tia_cnt_t     bit_cnt_reg;
	tia_cnt_t     bit_cnt_next;
	tia_byte_t    shift_reg;
	tia_byte_t    tx_reg;
	tia_byte_t    tx_next;
	tia_byte_t    rx_byte;
	logic         ack_reg;
	logic         ack_next;
	logic         byte_end;
	logic         ack_slot;
	logic         addr_hit;
	logic         oe_next;

	assign rx_byte  = {shift_reg[6:0], sda_in};
	assign byte_end = bit_cnt_reg == `TIA_LAST_BIT;
	assign ack_slot = bit_cnt_reg == `TIA_ACK_SLOT;
	assign addr_hit = rx_byte[7:1] == `TIA_SLAVE_ADDR;
	assign bit_cnt_next = ack_slot ? 4'h0 : bit_cnt_reg + 4'h1;
	assign tx_next = (byte_end && state_reg == ST_ADDR) ? rif.rd_data :
		(state_reg == ST_READ && !ack_slot) ? {tx_reg[6:0], 1'b0} : tx_reg;
	// ack low in the ninth slot, read data low bits otherwise
	assign oe_next = ack_slot ? ack_reg :
		(state_reg == ST_READ && !tx_reg[7]);

	always_comb
	begin
		state_next = state_reg;
		ack_next   = ack_reg;
		if (byte_end)
		begin
			ack_next = 1'b0;
			unique case (state_reg)
				ST_ADDR:
				begin
					ack_next   = addr_hit;
					state_next = !addr_hit ? ST_DONE :
						(rx_byte[0] == `TIA_DIR_READ) ? ST_READ : ST_INDEX;
				end
				ST_INDEX:
				begin
					ack_next   = 1'b1;
					state_next = ST_WDATA;
				end
				ST_WDATA:
				begin
					ack_next   = 1'b1;
					state_next = ST_DONE;
				end
				ST_READ,
				ST_DONE:
					state_next = ST_DONE;
			endcase
		end
	end

	always_ff @(posedge scl_clk or negedge link_rst_n_reg)
	begin
		if (!link_rst_n_reg)
		begin
			state_reg   <= ST_ADDR;
			bit_cnt_reg <= 4'h0;
			shift_reg   <= `TIA_RESET_BYTE;
			tx_reg      <= `TIA_RESET_BYTE;
			ack_reg     <= 1'b0;
		end
		else
		begin
			state_reg   <= state_next;
			bit_cnt_reg <= bit_cnt_next;
			shift_reg   <= rx_byte;
			tx_reg      <= tx_next;
			ack_reg     <= ack_next;
		end
	end

	// drive changes only while the clock is low
	always_ff @(negedge scl_clk or negedge link_rst_n_reg)
	begin
		if (!link_rst_n_reg)
			sda_oe <= 1'b0;
		else
			sda_oe <= oe_next;
	end

	assign sda_out = `TIA_SDA_LOW;

	// index survives the repeated start of a read
	always_ff @(posedge scl_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			index_reg  <= `TIA_RESET_BYTE;
			wdata_reg  <= `TIA_RESET_BYTE;
			wr_tgl_reg <= 1'b0;
		end
		else if (link_rst_n_reg && byte_end && state_reg == ST_INDEX)
			index_reg <= rx_byte;
		else if (link_rst_n_reg && byte_end && state_reg == ST_WDATA)
		begin
			wdata_reg  <= rx_byte;
			wr_tgl_reg <= !wr_tgl_reg;
		end
	end

	// ---- checks ----

	sequence start_seen_s;
		start_det ##1 frame_reg && !link_rst_n_reg;
	endsequence

	sequence engine_cleared_s;
		!link_rst_n_reg [*2];
	endsequence

	frame_open_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n) start_det |-> start_seen_s)
		else $error("start did not open a frame");
	stop_clear_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n) stop_det |=> engine_cleared_s)
		else $error("stop did not clear the link engine");
	pd_out_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n) rif.pd && en_s ##1 rif.pd && en_s
		|-> power_down_all)
		else $error("power down not driven");
	disabled_out_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n) !en_s |=> !power_down_all
		&& swing_select == 16'h0000 && bandwidth_select == 16'h0000)
		else $error("outputs active while serial control disabled");
	addr_nack_a: assert property (@(posedge scl_clk)
		disable iff (!link_rst_n_reg)
		state_reg == ST_ADDR && byte_end && !addr_hit
		|=> !ack_reg && state_reg == ST_DONE)
		else $error("foreign address acknowledged");
	ack_drive_a: assert property (@(posedge scl_clk)
		disable iff (!link_rst_n_reg)
		byte_end && ack_next |=> ack_slot && sda_oe)
		else $error("acknowledge not driven in ninth slot");
	extra_nack_a: assert property (@(posedge scl_clk)
		disable iff (!link_rst_n_reg)
		ack_slot && $past(state_reg) inside {ST_READ, ST_DONE} |-> !sda_oe)
		else $error("extra byte acknowledged");
	write_event_a: assert property (@(posedge scl_clk)
		disable iff (!rst_n || !link_rst_n_reg)
		state_reg == ST_WDATA && byte_end |=> $changed(wr_tgl_reg))
		else $error("data byte raised no write");
	read_drive_a: assert property (@(posedge scl_clk)
		disable iff (!link_rst_n_reg)
		state_reg == ST_READ && !ack_slot |-> sda_oe == !tx_reg[7])
		else $error("read bit not driven");
endmodule

// ### hw/tia_map.svh
// constants of the two-wire control slave
`ifndef TIA_MAP_SVH
`define TIA_MAP_SVH
`define TIA_SLAVE_ADDR 7'h0c
`define TIA_IDX_CTRL   8'h00
`define TIA_IDX_CH1    8'h01
`define TIA_IDX_CH2    8'h07
`define TIA_IDX_CH3    8'h0d
`define TIA_IDX_CH4    8'h13
`define TIA_BIT_RESET  7
`define TIA_BIT_PD     6
`define TIA_BIT_PWRITE 0
`define TIA_RESET_BYTE 8'h00
`define TIA_LAST_BIT   4'h7
`define TIA_ACK_SLOT   4'h8
`define TIA_DIR_READ   1'b1
`define TIA_SDA_LOW    1'b0
`endif

// ### hw/tia_pkg.sv
// types and shared decode of the two-wire control slave
`include "tia_map.svh"
package tia_pkg;
	typedef logic [7:0]  tia_byte_t;
	typedef logic [3:0]  tia_cnt_t;
	typedef logic [15:0] tia_quad_t;
	typedef logic [2:0]  tia_chan_t;
	typedef enum logic [2:0] {ST_ADDR, ST_INDEX, ST_WDATA, ST_READ,
		ST_DONE} tia_link_st_e;

	// bit 2 flags a channel amplitude/rate index, bits 1:0 the channel
	function automatic tia_chan_t tia_chan_of(input tia_byte_t idx);
		tia_chan_t r;
		r = 3'h0;
		if (idx == `TIA_IDX_CH1)
			r = 3'h4;
		if (idx == `TIA_IDX_CH2)
			r = 3'h5;
		if (idx == `TIA_IDX_CH3)
			r = 3'h6;
		if (idx == `TIA_IDX_CH4)
			r = 3'h7;
		return r;
	endfunction
endpackage

// ### hw/tia_reg_if.sv
// register access between link control and register bank
`timescale 1ns/100ps
interface tia_reg_if;
	logic                  wr_en;
	tia_pkg::tia_byte_t    wr_idx;
	tia_pkg::tia_byte_t    wr_data;
	tia_pkg::tia_byte_t    rd_idx;
	tia_pkg::tia_byte_t    rd_data;
	logic                  pd;
	logic                  pwrite;
	tia_pkg::tia_byte_t    amp_rate [4];
	modport bank (input wr_en, wr_idx, wr_data, rd_idx,
		output rd_data, pd, pwrite, amp_rate);
	modport ctrl (output wr_en, wr_idx, wr_data, rd_idx,
		input rd_data, pd, pwrite, amp_rate);
endinterface

// ### hw/tia_sync.sv
// two-flop synchroniser for levels and quasi-static words
`timescale 1ns/100ps
module tia_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,   // destination clock
	input  wire logic             rst_n, // async reset, active low
	input  wire logic [WIDTH-1:0] d,     // foreign level
	output logic      [WIDTH-1:0] q      // synchronised level
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_reg <= '0;
			q        <= '0;
		end
		else
		begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

// ### hw/tia_reg_bank.sv
// control and channel amplitude/rate registers
`timescale 1ns/100ps
`include "tia_map.svh"
module tia_reg_bank (
	input  wire logic clk,   // reference clock
	input  wire logic rst_n, // async reset, active low
	tia_reg_if.bank   rif    // register access
);
	import tia_pkg::*;

	tia_chan_t wr_chan;
	tia_chan_t rd_chan;
	logic      is_ctrl_wr;
	logic      soft_rst;
	tia_byte_t rd_next;

	assign wr_chan    = tia_chan_of(rif.wr_idx);
	assign rd_chan    = tia_chan_of(rif.rd_idx);
	assign is_ctrl_wr = rif.wr_en && rif.wr_idx == `TIA_IDX_CTRL;
	assign soft_rst   = is_ctrl_wr && rif.wr_data[`TIA_BIT_RESET];
	// reset bit and reserved bits always read as zero
	assign rd_next = (rif.rd_idx == `TIA_IDX_CTRL) ?
		{1'b0, rif.pd, 5'h00, rif.pwrite} :
		rd_chan[2] ? rif.amp_rate[rd_chan[1:0]] : `TIA_RESET_BYTE;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rif.pd     <= 1'b0;
			rif.pwrite <= 1'b0;
			rif.amp_rate <= '{default: `TIA_RESET_BYTE};
		end
		else if (soft_rst)
		begin
			rif.pd     <= 1'b0;
			rif.pwrite <= 1'b0;
			rif.amp_rate <= '{default: `TIA_RESET_BYTE};
		end
		else if (is_ctrl_wr)
		begin
			rif.pd     <= rif.wr_data[`TIA_BIT_PD];
			rif.pwrite <= rif.wr_data[`TIA_BIT_PWRITE];
		end
		else if (rif.wr_en && wr_chan[2])
		begin
			for (int i = 0; i < 4; i++)
			begin
				if (rif.pwrite || wr_chan[1:0] == 2'(i))
					rif.amp_rate[i] <= rif.wr_data;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rif.rd_data <= `TIA_RESET_BYTE;
		else
			rif.rd_data <= rd_next;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	soft_reset_a: assert property (soft_rst |=> !rif.pd && !rif.pwrite
		&& rif.amp_rate[0] == 8'h00 && rif.amp_rate[3] == 8'h00)
		else $error("soft reset left a register set");
	parallel_write_a: assert property (rif.wr_en && rif.pwrite
		&& wr_chan[2] |=> rif.amp_rate[0] == $past(rif.wr_data)
		&& rif.amp_rate[3] == $past(rif.wr_data))
		else $error("parallel write not mirrored");
	ctrl_read_a: assert property (rif.rd_idx == `TIA_IDX_CTRL
		|=> rif.rd_data[7] == 1'b0 && rif.rd_data[5:1] == 5'h00)
		else $error("control readback shows write-only bits");
endmodule

// ### testbench/tia_mst_model.sv
// two-wire bus master model for the control slave
`timescale 1ns/100ps
module tia_mst_model (
	output logic      scl,   // serial clock, idle high
	output logic      m_low, // master pulls data low
	input  wire logic sda,   // resolved data line
	output logic      coll   // sticky, sent byte read back wrong
);
	initial
	begin
		scl = 1'b1;
		m_low = 1'b0;
		coll = 1'b0;
	end

	// data moves only in the low phase, sampled at the rising edge
	task automatic bit_x(input logic b, output logic r);
		#4 m_low = !b;
		#28 scl = 1'b1;
		r = sda;
		#32 scl = 1'b0;
	endtask

	// eight bits msb first, ninth released for the receiver
	task automatic byte_x(input logic [7:0] d, input logic rx,
		output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], q[i]);
		if (!rx && q !== d)
			coll = 1'b1;
		bit_x(1'b1, ack);
	endtask

	task automatic start_c();
		#4 m_low = 1'b0;
		#100 scl = 1'b1;
		#300 m_low = 1'b1;
		#300 scl = 1'b0;
		#250;
	endtask

	task automatic stop_c();
		#4 m_low = 1'b1;
		#100 scl = 1'b1;
		#300 m_low = 1'b0;
		#400;
	endtask

	// acks: address, index, data or read address, extra or master nack
	task automatic frame(input logic [7:0] a, idx, d, input logic rd,
		extra, output logic [7:0] q, output logic [3:0] acks);
		logic [7:0] t;
		acks = 4'hf;
		q = 8'h00;
		start_c();
		byte_x(a, 1'b0, t, acks[3]);
		if (!acks[3])
		begin
			byte_x(idx, 1'b0, t, acks[2]);
			if (rd)
			begin
				start_c();
				byte_x(a | 8'h01, 1'b0, t, acks[1]);
				byte_x(8'hff, 1'b1, q, acks[0]);
			end
			else
			begin
				byte_x(d, 1'b0, t, acks[1]);
				if (extra)
					byte_x(8'h5a, 1'b0, t, acks[0]);
			end
		end
		stop_c();
	endtask
endmodule

// ### testbench/tb.sv
// self-checking bench of the two-wire control slave
`timescale 1ns/100ps
module tb;
	import tia_pkg::*;
	logic       ref_clk, rst_n, scl_clk, sda_out, sda_oe, en, pd_o;
	logic       m_low, coll, pd_m, pw_m;
	wire logic  sda_in;
	tia_quad_t  bw_o, sw_o;
	tia_byte_t  amp_m [4];
	tia_byte_t  q, idx, d;
	logic [3:0] acks;
	logic [7:0] bad_a [5] = '{8'h1a, 8'h30, 8'h98, 8'h1c, 8'h0c};
	tia_byte_t  tab [5] = '{8'h00, 8'h01, 8'h07, 8'h0d, 8'h13};
	int         num_errors, samples_checked, k;
	integer     seed;

	assign sda_in = !(m_low || (sda_oe && !sda_out));
	always #10 ref_clk = !ref_clk;

	tia_two_wire_control_slave dut_u (
		.ref_clk(ref_clk), .rst_n(rst_n), .scl_clk(scl_clk),
		.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
		.serial_control_enable(en), .power_down_all(pd_o),
		.bandwidth_select(bw_o), .swing_select(sw_o));
	tia_mst_model mst_u (.scl(scl_clk), .m_low(m_low), .sda(sda_in),
		.coll(coll));

	function automatic int ch_of(input tia_byte_t i);
		return i == 8'h01 ? 0 : i == 8'h07 ? 1 : i == 8'h0d ? 2 :
			i == 8'h13 ? 3 : -1;
	endfunction

	function automatic logic [15:0] rd_exp(input tia_byte_t i);
		if (i == 8'h00)
			return {9'h000, pd_m, 5'h00, pw_m};
		return ch_of(i) >= 0 ? {8'h00, amp_m[ch_of(i)]} : 16'h0000;
	endfunction

	task automatic clr_m();
		pd_m = 1'b0;
		pw_m = 1'b0;
		amp_m = '{4{8'h00}};
	endtask

	task automatic chk(input logic [15:0] g, e);
		samples_checked++;
		if (g !== e)
		begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
			num_errors++;
		end
	endtask

	task automatic final_report();
		if (num_errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk_out();
		logic [15:0] eb, es;
		for (int c = 0; c < 4; c++)
		begin
			eb[4*c+:4] = en ? amp_m[c][7:4] : 4'h0;
			es[4*c+:4] = en ? amp_m[c][3:0] : 4'h0;
		end
		chk(16'(pd_o), 16'(en & pd_m));
		chk(bw_o, eb);
		chk(sw_o, es);
	endtask

	task automatic wr(input tia_byte_t i, v, input logic ex);
		mst_u.frame(8'h18, i, v, 1'b0, ex, q, acks);
		chk(16'(acks), 16'h0001);
		if (en && i == 8'h00 && v[7])
			clr_m();
		else if (en && i == 8'h00)
			{pd_m, pw_m} = {v[6], v[0]};
		else if (en && ch_of(i) >= 0)
			for (int c = 0; c < 4; c++)
				if (pw_m || c == ch_of(i))
					amp_m[c] = v;
		chk_out();
	endtask

	task automatic rd(input tia_byte_t i);
		mst_u.frame(8'h18, i, 8'h00, 1'b1, 1'b0, q, acks);
		chk(16'(acks), 16'h0001);
		chk(16'(q), rd_exp(i));
	endtask

	initial
	begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		en = 1'b1;
		seed = 32'hb050cf53;
		clr_m();
		repeat (16) @(posedge ref_clk);
		#2 rst_n = 1'b1;
		repeat (8) @(posedge ref_clk);
		chk_out();
		rd(8'h00);
		rd(8'h01);
		wr(8'h00, 8'h3f, 1'b0);
		rd(8'h00);
		wr(8'h07, 8'hf7, 1'b1);
		wr(8'h00, 8'h40, 1'b0);
		wr(8'h0d, 8'h81, 1'b1);
		rd(8'h0e);
		for (k = 0; k < 5; k++)
		begin
			mst_u.frame(bad_a[k], 8'h01, 8'hff, 1'b0, 1'b0, q, acks);
			chk(16'(acks), 16'h000f);
		end
		chk_out();
		wr(8'h00, 8'hc1, 1'b0);
		rd(8'h00);
		rd(8'h07);
		for (k = 0; k < 40; k++)
		begin
			@(posedge ref_clk);
			#2 en = k < 2 ? 1'b0 : ($random(seed) & 7) != 0;
			idx = tab[$unsigned($random(seed)) % 5];
			if (k % 6 == 5)
				idx = 8'($random(seed)) & 8'h0f;
			d = 8'($random(seed));
			wr(idx, d, k[0]);
			rd(idx);
		end
		@(posedge ref_clk);
		#2 rst_n = 1'b0;
		repeat (3) @(posedge ref_clk);
		#2 rst_n = 1'b1;
		clr_m();
		repeat (8) @(posedge ref_clk);
		chk_out();
		rd(8'h01);
		chk(16'(coll), 16'h0000);
		final_report();
	end

	initial
	begin
		num_errors = 0;
		samples_checked = 0;
		repeat (90000) @(posedge ref_clk);
		num_errors++;
		final_report();
	end
endmodule
